//--- rtl/vgt_cfg.svh
// Offsets, field positions, reset values and fixed codes of the config block
`ifndef VGT_CFG_SVH
`define VGT_CFG_SVH
// Byte offsets
`define VGT_OFS_CAP_HDR 12'h150
`define VGT_OFS_PORT_CAP1 12'h154
`define VGT_OFS_PORT_CAP2 12'h158
`define VGT_OFS_PORT_CTL 12'h15c
`define VGT_OFS_VC0_CAP 12'h160
`define VGT_OFS_VC0_CTL 12'h164
`define VGT_OFS_VC0_STS 12'h168
`define VGT_OFS_XGPIO 12'h300
`define VGT_OFS_XIO 12'h304
`define VGT_OFS_TIMERS 12'h310
// Capability header
`define VGT_CAP_ID 16'h0002
`define VGT_CAP_VER 4'h1
`define VGT_NEXT_PTR 12'h000
// Channel-zero resource control
`define VGT_TC_MAP_RST 7'h7f
`define VGT_TC0_MAP 1'b1
`define VGT_VC_ENABLE 1'b1
`define VGT_TC_LSB 1
`define VGT_TC_MSB 7
// Extended GPIO fields
`define VGT_XG_OCLR_LSB 0
`define VGT_XG_OSET_LSB 3
`define VGT_XG_ECLR_LSB 6
`define VGT_XG_ESET_LSB 9
`define VGT_XG_IN_LSB 12
// Extra in/out fields
`define VGT_XO_OCLR_LSB 0
`define VGT_XO_OSET_LSB 3
`define VGT_XO_ECLR_LSB 8
`define VGT_XO_ESET_LSB 11
`define VGT_XO_IN_LSB 16
// Timers
`define VGT_RPL_LSB 0
`define VGT_RPL_EN_BIT 12
`define VGT_ACK_LSB 16
`define VGT_ACK_EN_BIT 30
`define VGT_RPL_RST 12'h115
`define VGT_ACKLAT_RST 14'h00cd
// SMBus address prefix, bits 7:5
`define VGT_SMB_PREFIX 3'h6
`endif

//--- rtl/vgt_pkg.sv
// Types shared by the config register block
package vgt_pkg;
    typedef enum logic [0:0] {
        VGT_IDLE = 1'b0,
        VGT_ACK = 1'b1
    } vgt_phase_e;

    typedef logic [2:0] vgt_tri_t;

    typedef struct packed {
        vgt_phase_e phase;
        logic wait_req;
        logic [31:0] rdata;
        logic [6:0] tc_map;
        vgt_tri_t xg_out;
        vgt_tri_t xg_oe;
        vgt_tri_t xg_in;
        vgt_tri_t xo_out;
        vgt_tri_t xo_oe;
        vgt_tri_t xi_in;
        vgt_tri_t gnt_n;
        vgt_tri_t gnt_oe;
        logic [11:0] rpl_val;
        logic rpl_en;
        logic [13:0] ack_val;
        logic ack_en;
        logic strap_done;
        logic smb_sel;
        logic smb_valid;
        logic [7:0] smb_addr;
    } vgt_state_s;
endpackage

//--- rtl/vgt_regs.sv
// Channel capability, extended GPIO and link timer config registers
//
// Chosen here: the Avalon-MM slave port.
`include "vgt_cfg.svh"

module vgt_regs
    import vgt_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [2:0] ext_gpio_i,
    output logic [2:0] ext_gpio_o,
    output logic [2:0] ext_gpio_oe_o,
    input wire logic ext_arbiter_sel_i,
    input wire logic [2:0] pci_req_n_i,
    input wire logic [2:0] int_gnt_n_i,
    output logic [2:0] pci_gnt_n_o,
    output logic [2:0] pci_gnt_oe_o,
    input wire logic [3:0] gpio_strap_i,
    input wire logic strap_select_low_i,
    input wire logic strap_select_high_i,
    output logic smbus_slave_sel_o,
    output logic smbus_addr_valid_o,
    output logic [7:0] smbus_addr_o,
    output logic [11:0] replay_timer_o,
    output logic replay_timer_en_o,
    output logic [13:0] ack_latency_o,
    output logic ack_latency_en_o
);

    localparam vgt_state_s VGT_RST = '{
        phase: VGT_IDLE,
        wait_req: 1'b1,
        rdata: 32'h0000_0000,
        tc_map: `VGT_TC_MAP_RST,
        xg_out: 3'h0,
        xg_oe: 3'h0,
        xg_in: 3'h0,
        xo_out: 3'h0,
        xo_oe: 3'h0,
        xi_in: 3'h0,
        gnt_n: 3'h7,
        gnt_oe: 3'h0,
        rpl_val: `VGT_RPL_RST,
        rpl_en: 1'b0,
        ack_val: `VGT_ACKLAT_RST,
        ack_en: 1'b0,
        strap_done: 1'b0,
        smb_sel: 1'b0,
        smb_valid: 1'b0,
        smb_addr: 8'h00
    };

    vgt_state_s st;
    vgt_state_s next_st;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic [31:0] rmux;
    logic do_write;

    // Spread byte enables over their lanes
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Clear then set; a set in the same write wins
    function automatic logic [2:0] clr_set(
        input logic [2:0] cur,
        input logic [2:0] clr,
        input logic [2:0] set
    );
        clr_set = (cur & ~clr) | set;
    endfunction

    // Read multiplexer over the current state
    always_comb begin
        rmux = 32'h0000_0000;
        case (avs_address_i)
            `VGT_OFS_CAP_HDR: begin
                rmux = {`VGT_NEXT_PTR, `VGT_CAP_VER, `VGT_CAP_ID};
            end
            `VGT_OFS_PORT_CAP1: begin
                rmux = 32'h0000_0000;
            end
            `VGT_OFS_PORT_CAP2: begin
                rmux = 32'h0000_0000;
            end
            `VGT_OFS_PORT_CTL: begin
                rmux = 32'h0000_0000;
            end
            `VGT_OFS_VC0_CAP: begin
                rmux = 32'h0000_0000;
            end
            `VGT_OFS_VC0_CTL: begin
                rmux = {`VGT_VC_ENABLE, 23'h00_0000, st.tc_map, `VGT_TC0_MAP};
            end
            `VGT_OFS_VC0_STS: begin
                rmux = 32'h0000_0000;
            end
            `VGT_OFS_XGPIO: begin
                rmux = {17'h0_0000, st.xg_in, st.xg_oe, st.xg_oe, st.xg_out, st.xg_out};
            end
            `VGT_OFS_XIO: begin
                if (ext_arbiter_sel_i) begin
                    rmux = {13'h0000, st.xi_in, 2'h0, st.xo_oe, st.xo_oe,
                            2'h0, st.xo_out, st.xo_out};
                end
            end
            `VGT_OFS_TIMERS: begin
                rmux = {1'b0, st.ack_en, st.ack_val, 3'h0, st.rpl_en, st.rpl_val};
            end
            default: begin
                rmux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        wmask = lane_mask(avs_byteenable_i);
        wd = avs_writedata_i & wmask;
        do_write = 1'b0;

        // Bus handshake: one wait cycle, then one cycle with waitrequest low
        case (st.phase)
            VGT_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    next_st.phase = VGT_ACK;
                    next_st.wait_req = 1'b0;
                    next_st.rdata = avs_read_i ? rmux : 32'h0000_0000;
                end
            end
            VGT_ACK: begin
                next_st.phase = VGT_IDLE;
                next_st.wait_req = 1'b1;
                // Read data stands for the answer cycle only
                next_st.rdata = 32'h0000_0000;
                do_write = avs_write_i;
            end
            default: begin
                next_st.phase = VGT_IDLE;
                next_st.wait_req = 1'b1;
            end
        endcase

        // Input pins sampled every cycle
        // sample extended inputs
        next_st.xg_in = ext_gpio_i;
        next_st.xi_in = pci_req_n_i;

        // Writes take effect at the edge where waitrequest is low
        if (do_write) begin
            case (avs_address_i)
                `VGT_OFS_VC0_CTL: begin
                    if (avs_byteenable_i[0]) begin
                        next_st.tc_map = wd[`VGT_TC_MSB:`VGT_TC_LSB];
                    end
                end
                // write one to clear or set
                `VGT_OFS_XGPIO: begin
                    next_st.xg_out = clr_set(st.xg_out,
                        wd[`VGT_XG_OCLR_LSB +: 3], wd[`VGT_XG_OSET_LSB +: 3]);
                    next_st.xg_oe = clr_set(st.xg_oe,
                        wd[`VGT_XG_ECLR_LSB +: 3], wd[`VGT_XG_ESET_LSB +: 3]);
                end
                `VGT_OFS_XIO: begin
                    if (ext_arbiter_sel_i) begin
                        next_st.xo_out = clr_set(st.xo_out,
                            wd[`VGT_XO_OCLR_LSB +: 3], wd[`VGT_XO_OSET_LSB +: 3]);
                        next_st.xo_oe = clr_set(st.xo_oe,
                            wd[`VGT_XO_ECLR_LSB +: 3], wd[`VGT_XO_ESET_LSB +: 3]);
                    end
                end
                `VGT_OFS_TIMERS: begin
                    if (avs_byteenable_i[0]) begin
                        next_st.rpl_val[7:0] = wd[7:0];
                    end
                    if (avs_byteenable_i[1]) begin
                        next_st.rpl_val[11:8] = wd[11:8];
                        next_st.rpl_en = wd[`VGT_RPL_EN_BIT];
                    end
                    if (avs_byteenable_i[2]) begin
                        next_st.ack_val[7:0] = wd[23:16];
                    end
                    if (avs_byteenable_i[3]) begin
                        next_st.ack_val[13:8] = wd[29:24];
                        next_st.ack_en = wd[`VGT_ACK_EN_BIT];
                    end
                end
                default: begin
                    next_st.tc_map = st.tc_map;
                end
            endcase
        end

        // grant pins driven by extra outputs when ext_arbiter_sel_i is set, else by int_gnt_n_i with all enables on
        if (ext_arbiter_sel_i) begin
            next_st.gnt_n = next_st.xo_out;
            next_st.gnt_oe = next_st.xo_oe;
        end else begin
            next_st.gnt_n = int_gnt_n_i;
            next_st.gnt_oe = 3'h7;
        end

        // Straps caught once, on the first edge after reset release
        if (!st.strap_done) begin
            next_st.strap_done = 1'b1;
            next_st.smb_sel = !strap_select_high_i && strap_select_low_i;
            next_st.smb_valid = strap_select_low_i;
            if (strap_select_low_i) begin
                next_st.smb_addr = {`VGT_SMB_PREFIX, gpio_strap_i, 1'b0};
            end else begin
                next_st.smb_addr = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= VGT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = st.wait_req;
    assign ext_gpio_o = st.xg_out;
    assign ext_gpio_oe_o = st.xg_oe;
    assign pci_gnt_n_o = st.gnt_n;
    assign pci_gnt_oe_o = st.gnt_oe;
    assign smbus_slave_sel_o = st.smb_sel;
    assign smbus_addr_valid_o = st.smb_valid;
    assign smbus_addr_o = st.smb_addr;
    assign replay_timer_o = st.rpl_val;
    assign replay_timer_en_o = st.rpl_en;
    assign ack_latency_o = st.ack_val;
    assign ack_latency_en_o = st.ack_en;

endmodule

//--- tb/tb_vgt_regs.sv
// Bench for the config register block
module tb_vgt_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, rd, wr, sel, lo, hi, wq, ssel, sval, rte, ate;
    logic [11:0] adr, rt;
    logic [31:0] wd, rdat, q;
    logic [3:0] be, id, strap;
    logic [2:0] gin, req, ign, go, goe, gn, gnoe;
    logic [13:0] at;
    logic [7:0] sadr, tgt;
    logic [11:0] ta [12] = '{12'h150, 12'h154, 12'h158, 12'h15c, 12'h160, 12'h164,
        12'h168, 12'h300, 12'h304, 12'h310, 12'h14c, 12'h16c};
    logic [31:0] tv [12] = '{32'h10002, 0, 0, 0, 0, 32'h800000ff, 0, 32'h5000, 0,
        32'hcd0115, 0, 0};
    int n_errors, check_count, cyc;

    vgt_regs i_vgt_regs (.core_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .ext_gpio_i(gin), .ext_gpio_o(go),
        .ext_gpio_oe_o(goe), .ext_arbiter_sel_i(sel), .pci_req_n_i(req),
        .int_gnt_n_i(ign), .pci_gnt_n_o(gn), .pci_gnt_oe_o(gnoe), .gpio_strap_i(strap),
        .strap_select_low_i(lo), .strap_select_high_i(hi), .smbus_slave_sel_o(ssel),
        .smbus_addr_valid_o(sval), .smbus_addr_o(sadr), .replay_timer_o(rt),
        .replay_timer_en_o(rte), .ack_latency_o(at), .ack_latency_en_o(ate));
    vgt_smb_host i_vgt_smb_host (.dev_id_i(id), .gpio_strap_o(strap), .target_addr_o(tgt));

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] b);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        be <= b;
        // Outputs read here still hold the values sampled at this edge
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        rst = 1; rd = 0; wr = 0; adr = 0; wd = 0; be = 0; sel = 0;
        lo = 1; hi = 0; id = 4'ha; gin = 3'h5; req = 3'h3; ign = 3'h6;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        chk("smb", {ssel, sval, sadr}, {2'b11, tgt});
        chk("gnt", {gnoe, gn}, 6'h3e);
        for (int i = 0; i < 12; i++) begin
            bus(0, ta[i], 0, 4'hf);
            chk("reset", q, tv[i]);
            if (i != 7 && i != 9) bus(1, ta[i], 32'hffffffff, 4'hf);
            bus(0, ta[i], 0, 4'hf);
            chk("ro", q, tv[i]);
        end
        bus(1, 12'h164, 0, 4'hf);
        bus(0, 12'h164, 0, 4'hf);
        chk("tcmap", q, 32'h80000001);
        bus(1, 12'h300, 32'h38, 4'hf);
        bus(1, 12'h300, 32'he05, 4'hf);
        @(negedge clk);
        chk("gpio", {goe, go}, 6'h3a);
        bus(0, 12'h300, 0, 4'hf);
        chk("gpiord", q, 32'h5fd2);
        bus(1, 12'h300, 32'h1ff, 4'hf);
        @(negedge clk);
        chk("gpioset", {goe, go}, 6'h07);
        bus(1, 12'h300, 32'hfff, 4'h2);
        @(negedge clk);
        chk("gpiolane", {goe, go}, 6'h3f);
        @(posedge clk);
        sel <= 1'b1;
        bus(0, 12'h304, 0, 4'hf);
        chk("xiodrop", q, 32'h30000);
        bus(1, 12'h304, 32'h3838, 4'hf);
        bus(1, 12'h304, 32'h2, 4'hf);
        @(negedge clk);
        chk("gntx", {gnoe, gn}, 6'h3d);
        bus(0, 12'h304, 0, 4'hf);
        chk("xiord", q, 32'h33f2d);
        sel <= 1'b0;
        bus(1, 12'h310, 32'hffffffff, 4'hf);
        @(negedge clk);
        chk("gntint", {gnoe, gn}, 6'h3e);
        chk("timers", {ate, at, rte, rt}, 28'hfffffff);
        bus(1, 12'h310, 0, 4'h1);
        bus(0, 12'h310, 0, 4'hf);
        chk("timerd", q, 32'h7fff1f00);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            rst <= 1'b1;
            lo <= (k == 0);
            hi <= (k == 0);
            id <= k ? 4'h3 : 4'h5;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
            repeat (3) @(negedge clk);
            chk("smbk", {ssel, sval, sadr}, {1'b0, lo, lo ? tgt : 8'h00});
            chk("rplrst", {rte, rt}, 13'h0115);
        end
        test_done();
    end
endmodule

//--- tb/vgt_props.sv
// Port checks for the config register block
module vgt_props (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [2:0] ext_gpio_o,
    input wire logic [2:0] ext_gpio_oe_o,
    input wire logic ext_arbiter_sel_i,
    input wire logic [2:0] int_gnt_n_i,
    input wire logic [2:0] pci_gnt_n_o,
    input wire logic [2:0] pci_gnt_oe_o,
    input wire logic [3:0] gpio_strap_i,
    input wire logic strap_select_low_i,
    input wire logic strap_select_high_i,
    input wire logic smbus_slave_sel_o,
    input wire logic [7:0] smbus_addr_o,
    input wire logic [11:0] replay_timer_o,
    input wire logic replay_timer_en_o,
    input wire logic [13:0] ack_latency_o,
    input wire logic ack_latency_en_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] wd_q;
    logic [5:0] io_q;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Write data and pin state of the ack cycle
    always_ff @(posedge core_clk_i) begin
        wd_q <= avs_writedata_i;
        io_q <= {ext_gpio_oe_o, ext_gpio_o};
    end
    a_req_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered in one cycle");
    a_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_idle_rdata: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
        else $error("read data not zero while waiting");
    a_gnt_internal: assert property (
        !rst_i && !ext_arbiter_sel_i |=> pci_gnt_n_o == $past(int_gnt_n_i)
        && pci_gnt_oe_o == 3'h7)
        else $error("grant pins not passed through");
    a_out_hold: assert property (
        avs_waitrequest_o |=> $stable({replay_timer_o, replay_timer_en_o, ack_latency_o,
        ack_latency_en_o, ext_gpio_o, ext_gpio_oe_o})) else $error("state moved without write");
    a_gpio_w1s: assert property (
        avs_write_i && !avs_waitrequest_o && avs_address_i == 12'h300
        && avs_byteenable_i == 4'hf |=> ext_gpio_o == ((io_q[2:0] & ~wd_q[2:0]) | wd_q[5:3])
        && ext_gpio_oe_o == ((io_q[5:3] & ~wd_q[8:6]) | wd_q[11:9]))
        else $error("gpio set or clear wrong");
    a_smb_strap: assert property ($fell(rst_i) |=> smbus_addr_o ==
        ($past(strap_select_low_i) ? {3'h6, $past(gpio_strap_i), 1'b0} : 8'h00))
        else $error("strapped address wrong");
    a_slave_pick: assert property ($fell(rst_i) |=> smbus_slave_sel_o ==
        ($past(strap_select_low_i) && !$past(strap_select_high_i)))
        else $error("slave select wrong");
    a_timer_reset: assert property ($fell(rst_i) |-> replay_timer_o == 12'h115
        && !replay_timer_en_o && ack_latency_o == 14'h00cd && !ack_latency_en_o)
        else $error("timer reset values wrong");
endmodule

bind vgt_regs vgt_props i_vgt_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ext_gpio_o(ext_gpio_o), .ext_gpio_oe_o(ext_gpio_oe_o),
    .ext_arbiter_sel_i(ext_arbiter_sel_i), .int_gnt_n_i(int_gnt_n_i),
    .pci_gnt_n_o(pci_gnt_n_o), .pci_gnt_oe_o(pci_gnt_oe_o), .gpio_strap_i(gpio_strap_i),
    .strap_select_low_i(strap_select_low_i), .strap_select_high_i(strap_select_high_i),
    .smbus_slave_sel_o(smbus_slave_sel_o), .smbus_addr_o(smbus_addr_o),
    .replay_timer_o(replay_timer_o), .replay_timer_en_o(replay_timer_en_o),
    .ack_latency_o(ack_latency_o), .ack_latency_en_o(ack_latency_en_o));

//--- tb/vgt_smb_host.sv
// SMBus host model: straps the device ID and forms the address it calls
module vgt_smb_host (
    input wire logic [3:0] dev_id_i,
    output logic [3:0] gpio_strap_o,
    output logic [7:0] target_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign gpio_strap_o = dev_id_i;
    assign target_addr_o = {3'h6, dev_id_i, 1'b0};
endmodule
